// [hdl/ita_pkg.sv]
// constants, register map and carrier types of the ignition timing adjust block
package ita_pkg;
    localparam int DW = 16;
    localparam int AW = 8;
    localparam int NPTS = 5;
    typedef logic signed [15:0] ita_angle_t;
    typedef logic [15:0] ita_word_t;
    // angles in hundredths of a degree, positive is advance
    localparam ita_angle_t ANGLE_LIMIT = 16'sh0FA0;
    localparam ita_angle_t SPAN_LIMIT = 16'sh0FA0;
    // loop current in hundredths of a milliamp
    localparam ita_word_t LOOP_LOW_END = 16'h0190;
    localparam ita_word_t LOOP_HIGH_END = 16'h07D0;
    localparam ita_word_t LOOP_SPAN = 16'h0640;
    localparam ita_word_t SPEED_MAX = 16'h1388;
    localparam logic [7:0] ENERGY_MIN = 8'h0F;
    localparam logic [7:0] ENERGY_MAX = 8'h64;
    localparam logic [2:0] POINT_COUNT_MAX = 3'h5;
    // timing
    localparam longint CLK_HZ = 64'h0000_0000_0131_2D00;
    localparam longint HOUR_S = 64'h0000_0000_0000_0E10;
    localparam longint HOUR_CYCLES = CLK_HZ * HOUR_S;
    // register offsets (word addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LOW_END = 8'h01;
    localparam logic [7:0] ADDR_HIGH_END = 8'h02;
    localparam logic [7:0] ADDR_FALLBACK = 8'h03;
    localparam logic [7:0] ADDR_B_OFFSET = 8'h04;
    localparam logic [7:0] ADDR_EARLY_A = 8'h05;
    localparam logic [7:0] ADDR_LATE_A = 8'h06;
    localparam logic [7:0] ADDR_EARLY_B = 8'h07;
    localparam logic [7:0] ADDR_LATE_B = 8'h08;
    localparam logic [7:0] ADDR_POINT_COUNT = 8'h09;
    localparam logic [7:0] ADDR_ENERGY = 8'h0A;
    localparam logic [7:0] ADDR_SAVE = 8'h0B;
    localparam logic [7:0] ADDR_ENERGY_SAVED = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h0D;
    localparam logic [7:0] ADDR_HOURS = 8'h0E;
    localparam logic [7:0] ADDR_CHECKSUM = 8'h0F;
    localparam logic [7:0] ADDR_REVISION = 8'h10;
    localparam logic [7:0] ADDR_MODEL = 8'h11;
    localparam logic [7:0] ADDR_ANGLE = 8'h12;
    localparam logic [7:0] ADDR_POINT_BASE = 8'h20;
    // control register fields
    localparam int CTRL_TOGGLE = 0;
    localparam int CTRL_KNOB = 1;
    localparam int CTRL_CURVE_A = 2;
    localparam int CTRL_CURVE_B = 3;
    localparam int CTRL_LOOP_A = 4;
    localparam int CTRL_LOOP_B = 5;
    localparam int CTRL_W = 6;
    // status register fields
    localparam int STAT_REJECT = 0;
    localparam int STAT_SCHED_B = 1;
    localparam int STAT_LOOP_LOST = 2;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h02;
    localparam ita_angle_t ANGLE_RESET = 16'sh0000;
    localparam ita_angle_t EARLY_RESET = 16'sh0FA0;
    localparam ita_angle_t LATE_RESET = -16'sh0FA0;
    localparam logic [7:0] ENERGY_RESET = 8'h64;
    localparam logic [2:0] COUNT_RESET = 3'h0;
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        ita_angle_t low_end_angle;
        ita_angle_t high_end_angle;
        ita_angle_t loop_fallback_angle;
        ita_angle_t b_offset;
        ita_angle_t earliest_limit_a;
        ita_angle_t latest_limit_a;
        ita_angle_t earliest_limit_b;
        ita_angle_t latest_limit_b;
        logic [2:0] point_count;
        logic [7:0] energy;
        logic [7:0] energy_saved;
    } ita_cfg_s;
    typedef struct packed {
        ita_angle_t knob;
        ita_angle_t loop;
        ita_angle_t curve;
        logic sched_b;
        logic loop_lost;
    } ita_contrib_s;
endpackage : ita_pkg

// [hdl/ita_core.sv]
// ignition timing adjust: loop, speed curve, schedules, limits, energy and info view
`timescale 1ns/100ps
// Notes on behaviour
// - loop current interpolates low toward high angle
// - lost or low loop uses fallback angle
// - loop and curve angles within forty degrees
// - refuse low/high angles differing over forty degrees
// - loop angles writable only if loop enabled
// - curve holds zero to five speed/angle points
// - zero points disables curve and point writes
// - points beyond count are rejected
// - point speed limited to 0..5000 rpm
// - schedule B curve only in toggle mode
// - toggle mode, open input selects A
// - toggle mode, closed input selects B
// - schedule B adds offset to all contributions
// - clamp to active schedule limits
// - energy level accepts 15..100 percent
// - energy live on entry, stored on save
// - info view: hours, checksum, revision, model
// - run/stop mode uses schedule A only
// - disabled knob contributes zero degrees
module ita_core
    import ita_pkg::*;
#(
    parameter longint HOUR_COUNT = HOUR_CYCLES,
    parameter logic [15:0] REVISION = 16'h0100, // arbitrary value
    parameter logic [15:0] MODEL = 16'h5A31 // arbitrary value
)
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic [AW-1:0] ADDR,
    input wire logic [DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DW-1:0] RDATA,
    input wire logic signed [15:0] KNOB_ANGLE,
    input wire logic [15:0] LOOP_CURRENT,
    input wire logic LOOP_PRESENT,
    input wire logic [15:0] ENGINE_SPEED,
    input wire logic INPUT_CLOSED,
    output logic signed [15:0] FIRING_ANGLE,
    output logic SCHED_B,
    output logic LOOP_LOST,
    output logic [7:0] ENERGY_LEVEL,
    output logic ENERGY_SAVE
);
    ita_cfg_s cfg;
    ita_cfg_s next_cfg;
    ita_contrib_s stage;
    ita_contrib_s next_stage;
    logic [15:0] pt_speed [NPTS];
    logic signed [15:0] pt_angle [NPTS];
    logic reject;
    logic [39:0] hour_div;
    logic [15:0] hours;
    logic [DW-1:0] next_rdata;

    // write decode
    wire ita_angle_t wangle = ita_angle_t'(WDATA);
    wire angle_ok = (wangle <= ANGLE_LIMIT) && (wangle >= -ANGLE_LIMIT);
    wire toggle_mode = cfg.ctrl[CTRL_TOGGLE];
    wire loop_cfg_en = cfg.ctrl[CTRL_LOOP_A] | cfg.ctrl[CTRL_LOOP_B];
    wire signed [16:0] span_low = 17'(wangle) - 17'(cfg.high_end_angle);
    wire signed [16:0] span_high = 17'(wangle) - 17'(cfg.low_end_angle);
    wire span_low_ok = (span_low <= 17'(SPAN_LIMIT)) && (span_low >= -17'(SPAN_LIMIT));
    wire span_high_ok = (span_high <= 17'(SPAN_LIMIT)) && (span_high >= -17'(SPAN_LIMIT));
    wire pt_region = (ADDR[7:4] == ADDR_POINT_BASE[7:4]);
    wire [2:0] pt_idx = ADDR[3:1];
    wire pt_is_angle = ADDR[0];
    wire pt_allowed = pt_region && (pt_idx < cfg.point_count);
    wire pt_speed_ok = pt_allowed && !pt_is_angle && (WDATA <= SPEED_MAX);
    wire pt_angle_ok = pt_allowed && pt_is_angle && angle_ok;
    wire energy_ok = (WDATA[7:0] >= ENERGY_MIN) && (WDATA[7:0] <= ENERGY_MAX)
        && (WDATA[15:8] == 8'h00);
    wire count_ok = (WDATA <= 16'(POINT_COUNT_MAX));

    logic wr_ok;
    always_comb
    begin
        next_cfg = cfg;
        wr_ok = 1'b1;
        if (WR)
        begin
            case (ADDR)
                ADDR_CTRL: next_cfg.ctrl = WDATA[CTRL_W-1:0];
                ADDR_LOW_END:
                begin
                    wr_ok = loop_cfg_en && angle_ok && span_low_ok;
                    if (wr_ok) next_cfg.low_end_angle = wangle;
                end
                ADDR_HIGH_END:
                begin
                    wr_ok = loop_cfg_en && angle_ok && span_high_ok;
                    if (wr_ok) next_cfg.high_end_angle = wangle;
                end
                ADDR_FALLBACK:
                begin
                    wr_ok = loop_cfg_en && angle_ok;
                    if (wr_ok) next_cfg.loop_fallback_angle = wangle;
                end
                ADDR_B_OFFSET:
                begin
                    wr_ok = toggle_mode && angle_ok;
                    if (wr_ok) next_cfg.b_offset = wangle;
                end
                ADDR_EARLY_A:
                begin
                    wr_ok = angle_ok;
                    if (wr_ok) next_cfg.earliest_limit_a = wangle;
                end
                ADDR_LATE_A:
                begin
                    wr_ok = angle_ok;
                    if (wr_ok) next_cfg.latest_limit_a = wangle;
                end
                ADDR_EARLY_B:
                begin
                    wr_ok = toggle_mode && angle_ok;
                    if (wr_ok) next_cfg.earliest_limit_b = wangle;
                end
                ADDR_LATE_B:
                begin
                    wr_ok = toggle_mode && angle_ok;
                    if (wr_ok) next_cfg.latest_limit_b = wangle;
                end
                ADDR_POINT_COUNT:
                begin
                    wr_ok = count_ok;
                    if (wr_ok) next_cfg.point_count = WDATA[2:0];
                end
                ADDR_ENERGY:
                begin
                    wr_ok = energy_ok;
                    if (wr_ok) next_cfg.energy = WDATA[7:0];
                end
                ADDR_SAVE: next_cfg.energy_saved = cfg.energy;
                ADDR_STATUS: wr_ok = 1'b1;
                default: wr_ok = !pt_region || pt_speed_ok || pt_angle_ok;
            endcase
        end
    end

    wire wr_refused = WR && !wr_ok;
    wire reject_clear = WR && (ADDR == ADDR_STATUS) && WDATA[STAT_REJECT];
    wire next_reject = wr_refused | (reject && !reject_clear);

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            cfg <= '{ctrl: CTRL_RESET, low_end_angle: ANGLE_RESET,
                high_end_angle: ANGLE_RESET, loop_fallback_angle: ANGLE_RESET,
                b_offset: ANGLE_RESET, earliest_limit_a: EARLY_RESET,
                latest_limit_a: LATE_RESET, earliest_limit_b: EARLY_RESET,
                latest_limit_b: LATE_RESET, point_count: COUNT_RESET,
                energy: ENERGY_RESET, energy_saved: ENERGY_RESET};
            reject <= 1'b0;
        end
        else if (CE)
        begin
            cfg <= next_cfg;
            reject <= next_reject; // set wins over clear
        end
    end

    // curve point storage
    generate
        for (genvar i = 0; i < NPTS; i++)
        begin : g_pt
            wire hit = WR && pt_region && (pt_idx == 3'(i)) && (pt_speed_ok || pt_angle_ok);
            always_ff @(posedge CLK or negedge RESETN)
            begin
                if (!RESETN)
                begin
                    pt_speed[i] <= 16'h0000;
                    pt_angle[i] <= ANGLE_RESET;
                end
                else if (CE && hit && pt_is_angle)
                    pt_angle[i] <= wangle;
                else if (CE && hit)
                    pt_speed[i] <= WDATA;
            end
        end
    endgenerate

    // schedule selection
    wire sched_b = toggle_mode && INPUT_CLOSED;
    wire loop_on = sched_b ? cfg.ctrl[CTRL_LOOP_B] : cfg.ctrl[CTRL_LOOP_A];
    wire curve_on = (sched_b ? cfg.ctrl[CTRL_CURVE_B] : cfg.ctrl[CTRL_CURVE_A])
        && (cfg.point_count != 3'h0);

    // loop contribution
    wire loop_low = !LOOP_PRESENT || (LOOP_CURRENT < LOOP_LOW_END);
    wire [15:0] loop_clip = (LOOP_CURRENT > LOOP_HIGH_END) ? LOOP_HIGH_END : LOOP_CURRENT;
    wire signed [31:0] loop_off = 32'(loop_clip - LOOP_LOW_END);
    wire signed [31:0] loop_diff = 32'(cfg.high_end_angle) - 32'(cfg.low_end_angle);
    wire signed [31:0] loop_q = (loop_diff * loop_off) / signed'(32'(LOOP_SPAN));
    wire ita_angle_t loop_interp = cfg.low_end_angle + 16'(loop_q);
    wire ita_angle_t loop_val = loop_low ? cfg.loop_fallback_angle : loop_interp;

    // speed curve contribution
    logic [NPTS-1:0] ge;
    generate
        for (genvar i = 0; i < NPTS; i++)
        begin : g_ge
            assign ge[i] = (3'(i) < cfg.point_count) && (ENGINE_SPEED >= pt_speed[i]);
        end
    endgenerate

    logic [2:0] seg;
    always_comb
    begin
        seg = 3'h0;
        for (int i = 0; i < NPTS; i++)
            if (ge[i]) seg = 3'(i);
    end

    wire [2:0] seg_nx = (seg == 3'(NPTS - 1)) ? seg : seg + 3'h1;
    wire hold_pt = (ge == '0) || (seg_nx >= cfg.point_count);
    wire signed [31:0] cv_den = 32'(pt_speed[seg_nx]) - 32'(pt_speed[seg]);
    wire signed [31:0] cv_num = (32'(pt_angle[seg_nx]) - 32'(pt_angle[seg]))
        * (32'(ENGINE_SPEED) - 32'(pt_speed[seg]));
    wire signed [31:0] cv_q = (cv_den > 32'sh0) ? cv_num / cv_den : 32'sh0;
    wire ita_angle_t curve_val = hold_pt ? pt_angle[seg] : pt_angle[seg] + 16'(cv_q);

    always_comb
    begin
        next_stage.knob = cfg.ctrl[CTRL_KNOB] ? KNOB_ANGLE : ANGLE_RESET;
        next_stage.loop = loop_on ? loop_val : ANGLE_RESET;
        next_stage.curve = curve_on ? curve_val : ANGLE_RESET;
        next_stage.sched_b = sched_b;
        next_stage.loop_lost = loop_low;
    end

    // sum, offset and clamp
    wire signed [18:0] sum = 19'(stage.knob) + 19'(stage.loop) + 19'(stage.curve)
        + (stage.sched_b ? 19'(cfg.b_offset) : 19'sh0);
    wire ita_angle_t early = stage.sched_b ? cfg.earliest_limit_b : cfg.earliest_limit_a;
    wire ita_angle_t late = stage.sched_b ? cfg.latest_limit_b : cfg.latest_limit_a;
    wire ita_angle_t clamped = (sum > 19'(early)) ? early :
        (sum < 19'(late)) ? late : 16'(sum);

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            stage <= '0;
            FIRING_ANGLE <= ANGLE_RESET;
            SCHED_B <= 1'b0;
            LOOP_LOST <= 1'b0;
        end
        else if (CE)
        begin
            stage <= next_stage;
            FIRING_ANGLE <= clamped;
            SCHED_B <= stage.sched_b;
            LOOP_LOST <= stage.loop_lost;
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ENERGY_LEVEL <= ENERGY_RESET;
            ENERGY_SAVE <= 1'b0;
        end
        else if (CE)
        begin
            ENERGY_LEVEL <= next_cfg.energy;
            ENERGY_SAVE <= WR && (ADDR == ADDR_SAVE);
        end
    end

    // operating hours
    wire hour_tick = (hour_div == 40'(HOUR_COUNT - 1));
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            hour_div <= 40'h00_0000_0000;
            hours <= 16'h0000;
        end
        else if (CE)
        begin
            hour_div <= hour_tick ? 40'h00_0000_0000 : hour_div + 40'h00_0000_0001;
            if (hour_tick) hours <= hours + 16'h0001;
        end
    end

    // checksum over stored configuration
    logic [15:0] checksum;
    always_comb
    begin
        checksum = 16'(cfg.ctrl) ^ cfg.low_end_angle ^ cfg.high_end_angle
            ^ cfg.loop_fallback_angle ^ cfg.b_offset ^ cfg.earliest_limit_a
            ^ cfg.latest_limit_a ^ cfg.earliest_limit_b ^ cfg.latest_limit_b
            ^ 16'(cfg.point_count) ^ 16'(cfg.energy_saved);
        for (int i = 0; i < NPTS; i++)
            checksum = checksum ^ pt_speed[i] ^ pt_angle[i];
    end

    // read mux
    wire [15:0] status = 16'({LOOP_LOST, SCHED_B, reject});
    always_comb
    begin
        case (ADDR)
            ADDR_CTRL: next_rdata = 16'(cfg.ctrl);
            ADDR_LOW_END: next_rdata = cfg.low_end_angle;
            ADDR_HIGH_END: next_rdata = cfg.high_end_angle;
            ADDR_FALLBACK: next_rdata = cfg.loop_fallback_angle;
            ADDR_B_OFFSET: next_rdata = cfg.b_offset;
            ADDR_EARLY_A: next_rdata = cfg.earliest_limit_a;
            ADDR_LATE_A: next_rdata = cfg.latest_limit_a;
            ADDR_EARLY_B: next_rdata = cfg.earliest_limit_b;
            ADDR_LATE_B: next_rdata = cfg.latest_limit_b;
            ADDR_POINT_COUNT: next_rdata = 16'(cfg.point_count);
            ADDR_ENERGY: next_rdata = 16'(cfg.energy);
            ADDR_ENERGY_SAVED: next_rdata = 16'(cfg.energy_saved);
            ADDR_STATUS: next_rdata = status;
            ADDR_HOURS: next_rdata = hours;
            ADDR_CHECKSUM: next_rdata = checksum;
            ADDR_REVISION: next_rdata = REVISION;
            ADDR_MODEL: next_rdata = MODEL;
            ADDR_ANGLE: next_rdata = FIRING_ANGLE;
            default:
                if (pt_region && pt_idx < 3'(NPTS))
                    next_rdata = pt_is_angle ? pt_angle[pt_idx] : pt_speed[pt_idx];
                else
                    next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            RDATA <= 16'h0000;
        else if (CE)
            RDATA <= RD ? next_rdata : 16'h0000;
    end
endmodule : ita_core

// [verification/ita_core_props.sv]
// assertion checker for the ignition timing adjust core
`timescale 1ns/100ps
module ita_core_props
    import ita_pkg::*;
#(
    parameter longint HOUR_COUNT = HOUR_CYCLES,
    parameter logic [15:0] REVISION = 16'h0100,
    parameter logic [15:0] MODEL = 16'h5A31
)
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic [AW-1:0] ADDR,
    input wire logic [DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [DW-1:0] RDATA,
    input wire logic signed [15:0] KNOB_ANGLE,
    input wire logic [15:0] LOOP_CURRENT,
    input wire logic LOOP_PRESENT,
    input wire logic [15:0] ENGINE_SPEED,
    input wire logic INPUT_CLOSED,
    input wire logic signed [15:0] FIRING_ANGLE,
    input wire logic SCHED_B,
    input wire logic LOOP_LOST,
    input wire logic [7:0] ENERGY_LEVEL,
    input wire logic ENERGY_SAVE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    sequence loop_gone;
        CE && (!LOOP_PRESENT || LOOP_CURRENT < LOOP_LOW_END);
    endsequence
    sequence energy_ok;
        CE && WR && ADDR == ADDR_ENERGY && WDATA >= {8'h00, ENERGY_MIN}
            && WDATA <= {8'h00, ENERGY_MAX};
    endsequence
    sequence save_req;
        CE && WR && ADDR == ADDR_SAVE;
    endsequence
    AST_LOOP_LOST_SET: assert property (loop_gone |-> ##2 LOOP_LOST)
        else $error("loop loss not flagged");
    AST_LOOP_LOST_CLR: assert property ((CE && LOOP_PRESENT
        && LOOP_CURRENT >= LOOP_LOW_END) |-> ##2 !LOOP_LOST)
        else $error("loop flagged lost while valid");
    AST_SCHED_A_OPEN: assert property ((CE && !INPUT_CLOSED) |-> ##2 !SCHED_B)
        else $error("schedule B with open input");
    AST_SCHED_B_CAUSE: assert property (SCHED_B |-> $past(INPUT_CLOSED, 2))
        else $error("schedule B without closed input");
    AST_ENERGY_RANGE: assert property (ENERGY_LEVEL >= ENERGY_MIN
        && ENERGY_LEVEL <= ENERGY_MAX) else $error("energy level out of range");
    AST_ENERGY_LIVE: assert property (energy_ok |=> ENERGY_LEVEL == $past(WDATA[7:0]))
        else $error("energy level not taken at once");
    AST_ENERGY_HOLD: assert property ($changed(ENERGY_LEVEL)
        |-> $past(CE && WR && ADDR == ADDR_ENERGY))
        else $error("energy level changed without entry");
    AST_SAVE_PULSE: assert property (save_req ##1 !(WR && ADDR == ADDR_SAVE)
        |-> ENERGY_SAVE ##1 !ENERGY_SAVE) else $error("save pulse wrong");
    AST_SAVE_CAUSE: assert property (ENERGY_SAVE |-> $past(CE && WR && ADDR == ADDR_SAVE))
        else $error("save pulse without command");
    AST_INFO_VIEW: assert property ((CE && RD && ADDR == ADDR_MODEL) |=> RDATA == MODEL)
        else $error("model name read wrong");
endmodule : ita_core_props
bind ita_core ita_core_props #(.HOUR_COUNT(HOUR_COUNT), .REVISION(REVISION),
    .MODEL(MODEL)) u_props (
    .CLK(CLK), .RESETN(RESETN), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .KNOB_ANGLE(KNOB_ANGLE), .LOOP_CURRENT(LOOP_CURRENT),
    .LOOP_PRESENT(LOOP_PRESENT), .ENGINE_SPEED(ENGINE_SPEED), .INPUT_CLOSED(INPUT_CLOSED),
    .FIRING_ANGLE(FIRING_ANGLE), .SCHED_B(SCHED_B), .LOOP_LOST(LOOP_LOST),
    .ENERGY_LEVEL(ENERGY_LEVEL), .ENERGY_SAVE(ENERGY_SAVE)
);

// [verification/ita_src_model.sv]
// model of the analog loop source and the engine speed sensing
`timescale 1ns/100ps
module ita_src_model
    import ita_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] set_ma,
    input wire logic set_present,
    input wire logic [15:0] set_rpm,
    output logic [15:0] loop_current,
    output logic loop_present,
    output logic [15:0] engine_speed
);
    // a broken loop has no defined current, so the level flips every cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            loop_current <= 16'h0000;
            loop_present <= 1'b0;
            engine_speed <= 16'h0000;
        end
        else
        begin
            loop_present <= set_present;
            loop_current <= set_present ? set_ma : ~loop_current;
            engine_speed <= set_rpm;
        end
    end
endmodule : ita_src_model

// [verification/ignition_timing_adjust_tb_top.sv]
// self-checking bench of the ignition timing adjust core
`timescale 1ns/100ps
module ignition_timing_adjust_tb_top;
    import ita_pkg::*;
    logic CLK, RESETN, CE, WR, RD, INPUT_CLOSED, SCHED_B, LOOP_LOST, LOOP_PRESENT, ENERGY_SAVE;
    logic set_present;
    logic [7:0] ADDR, ENERGY_LEVEL;
    logic [15:0] WDATA, RDATA, LOOP_CURRENT, ENGINE_SPEED, set_ma, set_rpm, v;
    logic signed [15:0] KNOB_ANGLE, FIRING_ANGLE;
    logic [5:0] ctrl;
    int fail_count, check_count, i, r, low, high, fb, boff, ea, la, eb, lb, cnt;
    int spd[5], ang[5];
    ita_src_model src (.clk(CLK), .resetn(RESETN), .set_ma(set_ma), .set_present(set_present),
        .set_rpm(set_rpm), .loop_current(LOOP_CURRENT), .loop_present(LOOP_PRESENT),
        .engine_speed(ENGINE_SPEED));
    ita_core #(.HOUR_COUNT(10)) dut (.CLK(CLK), .RESETN(RESETN), .CE(CE), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .KNOB_ANGLE(KNOB_ANGLE),
        .LOOP_CURRENT(LOOP_CURRENT), .LOOP_PRESENT(LOOP_PRESENT), .ENGINE_SPEED(ENGINE_SPEED),
        .INPUT_CLOSED(INPUT_CLOSED), .FIRING_ANGLE(FIRING_ANGLE), .SCHED_B(SCHED_B),
        .LOOP_LOST(LOOP_LOST), .ENERGY_LEVEL(ENERGY_LEVEL), .ENERGY_SAVE(ENERGY_SAVE));
    task test_done;
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic int rnd(input int lo, input int hi);
        return lo + int'($urandom_range(hi - lo));
    endfunction : rnd
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd
    task rdc(input logic [7:0] a, input logic [15:0] e);
        rd(a, v);
        chk(v, e);
    endtask : rdc
    // write, confirm the reject flag, and track accepted values
    task wr_exp(input logic [7:0] a, input int d, input logic rej);
        int k;
        k = (int'(a) - 32) / 2;
        wr(a, d[15:0]);
        rd(ADDR_STATUS, v);
        chk({15'h0, v[0]}, {15'h0, rej});
        if (rej)
            wr(ADDR_STATUS, 16'h0001);
        else
            case (a)
                ADDR_CTRL: ctrl = d[5:0];
                ADDR_LOW_END: low = d;
                ADDR_HIGH_END: high = d;
                ADDR_FALLBACK: fb = d;
                ADDR_B_OFFSET: boff = d;
                ADDR_EARLY_A: ea = d;
                ADDR_LATE_A: la = d;
                ADDR_EARLY_B: eb = d;
                ADDR_LATE_B: lb = d;
                ADDR_POINT_COUNT: cnt = d;
                default:
                    if (a >= ADDR_POINT_BASE && a[0])
                        ang[k] = d;
                    else if (a >= ADDR_POINT_BASE)
                        spd[k] = d;
            endcase
    endtask : wr_exp
    function automatic logic signed [15:0] exp_fa(input int kn, cur, pres, rpm, cl);
        int t;
        int c;
        int j;
        logic b;
        b = ctrl[0] & cl[0];
        t = ctrl[1] ? kn : 0;
        c = cur > 2000 ? 2000 : cur;
        if (ctrl[b ? 5 : 4])
            t += (!pres || cur < 400) ? fb : low + (high - low) * (c - 400) / 1600;
        if (ctrl[b ? 3 : 2] && cnt > 0)
        begin
            c = ang[cnt - 1];
            for (j = cnt - 1; j > 0; j--)
                if (rpm < spd[j])
                    c = ang[j - 1] + (ang[j] - ang[j - 1]) * (rpm - spd[j - 1])
                        / (spd[j] - spd[j - 1]);
            if (rpm <= spd[0])
                c = ang[0];
            t += c;
        end
        if (b)
            t += boff;
        if (t > (b ? eb : ea))
            t = b ? eb : ea;
        if (t < (b ? lb : la))
            t = b ? lb : la;
        return t[15:0];
    endfunction : exp_fa
    task ang_chk(input int kn, cur, pres, rpm, cl);
        @(posedge CLK);
        KNOB_ANGLE <= kn[15:0];
        INPUT_CLOSED <= cl[0];
        set_ma <= cur[15:0];
        set_present <= pres[0];
        set_rpm <= rpm[15:0];
        repeat (5) @(posedge CLK);
        #1 chk(FIRING_ANGLE, exp_fa(kn, cur, pres, rpm, cl));
        chk({15'h0, SCHED_B}, {15'h0, ctrl[0] & cl[0]});
    endtask : ang_chk
    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    initial
    begin
        repeat (60000) @(posedge CLK);
        fail_count++;
        test_done;
    end
    initial
    begin
        {RESETN, WR, RD, INPUT_CLOSED, set_present} = 5'h00;
        CE = 1'b1;
        {ADDR, WDATA, KNOB_ANGLE, set_ma, set_rpm} = 72'h0;
        {fail_count, check_count, low, high, fb, boff, cnt} = 224'h0;
        ea = 4000;
        la = -4000;
        eb = 4000;
        lb = -4000;
        ctrl = 6'h02;
        spd = '{5{0}};
        ang = '{5{0}};
        r = $urandom(53285);
        repeat (10) @(posedge CLK);
        RESETN <= 1'b1;
        rdc(ADDR_CTRL, 16'h0002);
        rdc(ADDR_ENERGY_SAVED, 16'h0064);
        rdc(ADDR_REVISION, 16'h0100);
        rdc(ADDR_MODEL, 16'h5A31);
        for (i = 0; i < 4; i++)
            ang_chk(rnd(-4000, 4000), 0, 0, 0, 0);
        wr_exp(ADDR_CTRL, 0, 0);
        ang_chk(1234, 0, 0, 0, 0);
        wr_exp(ADDR_LOW_END, 100, 1);
        wr_exp(ADDR_CTRL, 16'h10, 0);
        wr_exp(ADDR_LOW_END, 1000, 0);
        wr_exp(ADDR_HIGH_END, -3001, 1);
        wr_exp(ADDR_HIGH_END, -1500, 0);
        wr_exp(ADDR_FALLBACK, 4001, 1);
        wr_exp(ADDR_FALLBACK, -400, 0);
        ang_chk(0, 400, 1, 0, 0);
        ang_chk(0, 2000, 1, 0, 0);
        ang_chk(0, 399, 1, 0, 0);
        for (i = 0; i < 12; i++)
            ang_chk(0, rnd(300, 2100), int'(i % 4 != 3), 0, 0);
        wr_exp(ADDR_CTRL, 16'h04, 0);
        wr_exp(ADDR_POINT_BASE, 0, 1);
        wr_exp(ADDR_POINT_COUNT, 6, 1);
        wr_exp(ADDR_POINT_COUNT, 3, 0);
        wr_exp(8'h26, 10, 1);
        wr_exp(8'h24, 5001, 1);
        wr_exp(8'h24, 5000, 0);
        wr_exp(8'h22, 50, 0);
        wr_exp(8'h23, -1500, 0);
        for (i = 0; i < 10; i++)
            ang_chk(0, 0, 0, rnd(0, 5500), 0);
        ang_chk(0, 0, 0, 50, 0);
        wr_exp(ADDR_POINT_COUNT, 0, 0);
        ang_chk(0, 0, 0, 25, 0);
        wr_exp(ADDR_POINT_COUNT, 3, 0);
        wr_exp(ADDR_B_OFFSET, -200, 1);
        wr_exp(ADDR_CTRL, 16'h3F, 0);
        wr_exp(ADDR_B_OFFSET, -200, 0);
        wr_exp(ADDR_EARLY_A, 2500, 0);
        wr_exp(ADDR_LATE_A, 500, 0);
        wr_exp(ADDR_EARLY_B, 2300, 0);
        wr_exp(ADDR_LATE_B, 300, 0);
        for (i = 0; i < 16; i++)
            ang_chk(rnd(0, 3000), rnd(300, 2100), int'(i % 3 != 0),
                rnd(0, 1500), rnd(0, 1));
        ang_chk(4000, 2000, 1, 5000, 1);
        ang_chk(-4000, 400, 1, 50, 0);
        wr_exp(ADDR_CTRL, 16'h3E, 0);
        ang_chk(1000, 1000, 1, 500, 1);
        wr_exp(ADDR_ENERGY, 14, 1);
        wr_exp(ADDR_ENERGY, 101, 1);
        wr_exp(ADDR_ENERGY, 15, 0);
        wr_exp(ADDR_ENERGY, 50, 0);
        chk({8'h00, ENERGY_LEVEL}, 16'h0032);
        rdc(ADDR_ENERGY_SAVED, 16'h0064);
        wr(ADDR_SAVE, 16'h0001);
        rdc(ADDR_ENERGY_SAVED, 16'h0032);
        rd(ADDR_HOURS, v);
        chk({15'h0, v === 16'h0000}, 16'h0000);
        test_done;
    end
endmodule : ignition_timing_adjust_tb_top
